// ==== smbus_cfg_pkg.sv ====
// constants, field positions and enumerations of the configuration slave
// assumes: imported by the top module and its test bench; the fifo and synchroniser do not import it
package smbus_cfg_pkg;

  // own 7-bit address, i.e. D2h once the write bit is appended
  localparam logic [6:0] SLAVE_ADDR = 7'h69;
  localparam int CMD_MODE_BIT = 7;
  localparam int IDX_W = 7;
  localparam int CFG_BYTES = 16;
  localparam int DATA_W = 8;
  localparam int WORD_W = IDX_W + DATA_W;
  localparam int FIFO_DEPTH = 16;
  localparam int BIT_COUNT = 8;

  // count returned first in a block read
  localparam logic [7:0] BLOCK_COUNT = 8'(CFG_BYTES);

  // power-up values, byte k at bits [8k +: 8]
  localparam logic [CFG_BYTES*8-1:0] CFG_DEFAULTS =
    128'h0000_0000_0000_0000_0000_0000_007F_FF00;

  typedef enum logic [2:0] {
    LS_IDLE,
    LS_RX,
    LS_ACK,
    LS_TX,
    LS_MACK
  } link_state_t;

  typedef enum logic [1:0] {
    PH_ADDR,
    PH_CMD,
    PH_COUNT,
    PH_DATA
  } phase_t;

endpackage : smbus_cfg_pkg

// ==== stream_if.sv ====
// valid/ready word stream between the modules of the slave
// assumes: producer drives valid and data, consumer drives ready
interface stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : stream_if

// ==== bit_sync.sv ====
// two-stage level synchroniser, one struct of state
// assumes: d is stable long enough for a multi-bit value to be gray coded
module bit_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;

  sync_t r;
  sync_t n;

  // first stage is read only by the second
  always_comb begin
    n = r;
    n.s1 = d;
    n.s2 = r.s1;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign q = r.s2;
endmodule : bit_sync

// ==== cfg_fifo.sv ====
// dual-clock fifo with gray pointers carrying written bytes
// assumes: each side has its own synchronous active-low reset and enable
module cfg_fifo #(
  parameter int W = 15,
  parameter int DEPTH = 16
) (
  input wire logic wr_clk,
  input wire logic wr_nrst,
  input wire logic wr_ce,
  stream_if.snk wr,
  input wire logic rd_clk,
  input wire logic rd_nrst,
  input wire logic rd_ce,
  stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0] bin;
    logic [AW:0] gray;
  } wside_t;

  typedef struct packed {
    logic [AW:0] bin;
    logic [AW:0] gray;
  } rside_t;

  wside_t w_r;
  wside_t w_n;
  rside_t r_r;
  rside_t r_n;
  logic [AW:0] rgray_s;
  logic [AW:0] wgray_s;
  logic [AW:0] wb;
  logic [AW:0] rb;

  // full when the write pointer is one lap ahead of the read pointer
  assign wr.ready = (w_r.gray != {~rgray_s[AW:AW-1], rgray_s[AW-2:0]});
  assign rd.valid = (r_r.gray != wgray_s);
  assign rd.data = w_r.mem[r_r.bin[AW-1:0]];

  always_comb begin
    w_n = w_r;
    wb = w_r.bin + 1'b1;
    if (wr.valid && wr.ready) begin
      w_n.mem[w_r.bin[AW-1:0]] = wr.data;
      w_n.bin = wb;
      w_n.gray = wb ^ (wb >> 1);
    end
  end

  always_comb begin
    r_n = r_r;
    rb = r_r.bin + 1'b1;
    if (rd.valid && rd.ready) begin
      r_n.bin = rb;
      r_n.gray = rb ^ (rb >> 1);
    end
  end

  always_ff @(posedge wr_clk) begin
    if (!wr_nrst) begin
      w_r <= '0;
    end else if (wr_ce) begin
      w_r <= w_n;
    end
  end

  always_ff @(posedge rd_clk) begin
    if (!rd_nrst) begin
      r_r <= '0;
    end else if (rd_ce) begin
      r_r <= r_n;
    end
  end

  // pointer crossings, gray so only one bit moves at a time
  bit_sync #(.W(AW + 1)) u_rsync (
    .clk(wr_clk),
    .nrst(wr_nrst),
    .d(r_r.gray),
    .q(rgray_s)
  );

  bit_sync #(.W(AW + 1)) u_wsync (
    .clk(rd_clk),
    .nrst(rd_nrst),
    .d(w_r.gray),
    .q(wgray_s)
  );
endmodule : cfg_fifo

// ==== smbus_config_slave.sv ====
// two-wire configuration slave: link engine on link_clk, bytes applied on core_clk
// assumes: scl/sda are open-drain pins resolved outside, link_clk oversamples them
//
// Summary of operation
// - Only address 69h (D2h to write, D3h to read, 7-bit 69h plus the r/w bit) is answered, and the host uses it.
// - Command bit 7 at 0 selects a block transfer, at 1 a single byte transfer.
// - For single byte transfers the low seven command bits pick the byte index.
// - Block transfers run from byte 0 upward, each byte most significant bit first.
// - The host may stop after any whole byte, and completed bytes are kept.
// - Block write is address, command, count, data bytes, all acknowledged by the device.
// - Block read restarts with a read address, then the device returns a count and data.
// - Every configuration byte takes its default at power-up.
// - Byte write, byte read, block write and block read are all supported.
// - Written bytes switch the clock output buffers at any time.
// - Byte write and byte read follow the single byte framing with host nack on reads.
module smbus_config_slave
  import smbus_cfg_pkg::*;
#(
  parameter int DEPTH = smbus_cfg_pkg::FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic link_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe,
  output logic sda_out,
  output logic sda_oe,
  output logic [smbus_cfg_pkg::CFG_BYTES*8-1:0] cfg_bytes
);
  import smbus_cfg_pkg::*;

  typedef struct packed {
    link_state_t state;
    phase_t phase;
    logic [3:0] cnt;
    logic [7:0] sr;
    logic rw;
    logic is_byte;
    logic head_sent;
    logic nack;
    logic push;
    logic sda_drv;
    logic scl_hold;
    logic scl_q;
    logic sda_q;
    logic [IDX_W-1:0] idx;
    logic [CFG_BYTES-1:0][7:0] shadow;
  } lnk_t;

  typedef struct packed {
    logic [CFG_BYTES-1:0][7:0] cfg;
  } core_t;

  lnk_t r;
  lnk_t n;
  core_t c_r;
  core_t c_n;
  logic lnk_nrst;
  logic ce_l;
  logic scl_s;
  logic sda_s;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic byte_end;
  logic [IDX_W-1:0] pop_idx;

  stream_if #(.W(WORD_W)) wr_if ();
  stream_if #(.W(WORD_W)) rd_if ();

  // reset and enable reach the link side as levels, two flops each
  bit_sync #(.W(2)) u_ctl_sync (
    .clk(link_clk),
    .nrst(1'b1),
    .d({nrst, ce}),
    .q({lnk_nrst, ce_l})
  );

  // pins come from another clock domain; no reset here, so the samples already
  // show the idle high bus when the engine leaves reset and no false edge is seen
  bit_sync #(.W(2)) u_pin_sync (
    .clk(link_clk),
    .nrst(1'b1),
    .d({scl_in, sda_in}),
    .q({scl_s, sda_s})
  );

  // bus events from synchronised samples
  assign rise = scl_s && !r.scl_q;
  assign fall = !scl_s && r.scl_q;
  assign start = scl_s && r.scl_q && r.sda_q && !sda_s;
  assign stop = scl_s && r.scl_q && !r.sda_q && sda_s;
  assign byte_end = (r.state == LS_RX) && fall && (r.cnt == 4'(BIT_COUNT));

  // next byte to shift out: count first in a block read, then the bytes
  function automatic lnk_t load_tx(lnk_t s);
    lnk_t t;
    t = s;
    if (!s.is_byte && !s.head_sent) begin
      t.sr = BLOCK_COUNT;
      t.head_sent = 1'b1;
    end else begin
      t.sr = (s.idx < IDX_W'(CFG_BYTES)) ? s.shadow[s.idx] : 8'h00;
      t.idx = s.idx + 1'b1;
    end
    t.sda_drv = !t.sr[7];
    t.cnt = 4'h0;
    t.state = LS_TX;
    return t;
  endfunction : load_tx

  // link engine
  always_comb begin
    n = r;
    n.scl_q = scl_s;
    n.sda_q = sda_s;
    // a byte handed to the fifo also lands in the read-back copy
    if (r.push && wr_if.ready) begin
      n.push = 1'b0;
      n.shadow[r.idx] = r.sr;
      n.idx = r.idx + 1'b1;
    end
    unique case (r.state)
      LS_IDLE: begin
      end
      LS_RX: begin
        if (rise) begin
          n.sr = {r.sr[6:0], sda_s};
          n.cnt = r.cnt + 1'b1;
        end else if (byte_end) begin
          n.cnt = 4'h0;
          n.state = LS_ACK;
          n.sda_drv = 1'b1;
          unique case (r.phase)
            PH_ADDR: begin
              if (r.sr[7:1] != SLAVE_ADDR) begin
                n.state = LS_IDLE;
                n.sda_drv = 1'b0;
              end else begin
                n.rw = r.sr[0];
              end
            end
            PH_CMD: begin
              n.is_byte = r.sr[CMD_MODE_BIT];
              // block transfers always begin at byte 0
              n.idx = r.sr[CMD_MODE_BIT] ? r.sr[IDX_W-1:0] : '0;
              n.head_sent = 1'b0;
            end
            PH_COUNT: begin
            end
            PH_DATA: begin
              // bytes past the map are acknowledged and dropped
              if (r.idx < IDX_W'(CFG_BYTES)) begin
                n.push = 1'b1;
              end else begin
                n.idx = r.idx + 1'b1;
              end
            end
          endcase
        end
      end
      LS_ACK: begin
        if (fall) begin
          n.sda_drv = 1'b0;
          n.state = LS_RX;
          unique case (r.phase)
            PH_ADDR: n.phase = PH_CMD;
            PH_CMD: n.phase = r.is_byte ? PH_DATA : PH_COUNT;
            PH_COUNT: n.phase = PH_DATA;
            PH_DATA: n.phase = PH_DATA;
          endcase
          if (r.phase == PH_ADDR && r.rw) begin
            n = load_tx(n);
            n.phase = PH_DATA;
          end
        end
      end
      LS_TX: begin
        if (fall) begin
          if (r.cnt == 4'(BIT_COUNT - 1)) begin
            n.state = LS_MACK;
            n.sda_drv = 1'b0;
          end else begin
            n.sr = {r.sr[6:0], 1'b0};
            n.sda_drv = !r.sr[6];
            n.cnt = r.cnt + 1'b1;
          end
        end
      end
      LS_MACK: begin
        if (rise) begin
          n.nack = sda_s;
        end else if (fall) begin
          if (r.nack) begin
            n.state = LS_IDLE;
          end else begin
            n = load_tx(n);
          end
        end
      end
    endcase
    // start and stop win over any bit in progress; a pending byte still lands
    if (start) begin
      n.state = LS_RX;
      n.phase = PH_ADDR;
      n.cnt = 4'h0;
      n.rw = 1'b0;
      n.sda_drv = 1'b0;
    end else if (stop) begin
      n.state = LS_IDLE;
      n.sda_drv = 1'b0;
    end
    // stretch the low phase of the ack until the fifo takes the pending byte
    n.scl_hold = (n.state == LS_ACK) && n.push;
  end

  always_ff @(posedge link_clk) begin
    if (!lnk_nrst) begin
      r <= '0;
      r.shadow <= CFG_DEFAULTS;
      r.scl_q <= 1'b1;
      r.sda_q <= 1'b1;
    end else if (ce_l) begin
      r <= n;
    end
  end

  // open-drain pins only ever pull low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = r.scl_hold;
  assign sda_oe = r.sda_drv;
  assign wr_if.valid = r.push;
  assign wr_if.data = {r.idx, r.sr};

  cfg_fifo #(.W(WORD_W), .DEPTH(DEPTH)) u_fifo (
    .wr_clk(link_clk),
    .wr_nrst(lnk_nrst),
    .wr_ce(ce_l),
    .wr(wr_if),
    .rd_clk(core_clk),
    .rd_nrst(nrst),
    .rd_ce(ce),
    .rd(rd_if)
  );

  // core side applies each byte as it arrives
  assign rd_if.ready = 1'b1;
  assign pop_idx = rd_if.data[WORD_W-1:DATA_W];

  always_comb begin
    c_n = c_r;
    if (rd_if.valid && pop_idx < IDX_W'(CFG_BYTES)) begin
      c_n.cfg[pop_idx] = rd_if.data[DATA_W-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      c_r.cfg <= CFG_DEFAULTS;
    end else if (ce) begin
      c_r <= c_n;
    end
  end

  assign cfg_bytes = c_r.cfg;

  // checks on the link engine and the core side
  a_addr_foreign_ignored: assert property (@(posedge link_clk) disable iff (!lnk_nrst)
    ce_l && byte_end && r.phase == PH_ADDR && r.sr[7:1] != SLAVE_ADDR && !start && !stop
    |=> r.state == LS_IDLE && !r.sda_drv && !sda_oe)
    else $error("foreign address was acknowledged");

  a_addr_own_acked: assert property (@(posedge link_clk) disable iff (!lnk_nrst)
    ce_l && byte_end && r.phase == PH_ADDR && r.sr[7:1] == SLAVE_ADDR && !start && !stop
    |=> r.state == LS_ACK && sda_oe && r.rw == $past(r.sr[0]))
    else $error("own address not acknowledged");

  a_cmd_mode_split: assert property (@(posedge link_clk) disable iff (!lnk_nrst)
    ce_l && byte_end && r.phase == PH_CMD && !start && !stop
    |=> r.is_byte == $past(r.sr[7]) && !r.head_sent)
    else $error("command mode bit misdecoded");

  a_cmd_byte_index: assert property (@(posedge link_clk) disable iff (!lnk_nrst)
    ce_l && byte_end && r.phase == PH_CMD && r.sr[7] && !start && !stop
    |=> r.idx == $past(r.sr[6:0]))
    else $error("byte index not taken from command");

  a_block_count_phase: assert property (@(posedge link_clk) disable iff (!lnk_nrst)
    ce_l && r.state == LS_ACK && r.phase == PH_CMD && !r.is_byte && fall && !start && !stop
    |=> r.phase == PH_COUNT ##0 r.state == LS_RX)
    else $error("block write skipped the count");

  a_data_ascending: assert property (@(posedge link_clk) disable iff (!lnk_nrst)
    ce_l && r.push && wr_if.ready
    |=> r.idx == IDX_W'($past(r.idx) + 1'b1) && r.shadow[$past(r.idx)] == $past(r.sr))
    else $error("stored byte or index order wrong");

  a_data_acked: assert property (@(posedge link_clk) disable iff (!lnk_nrst)
    ce_l && byte_end && r.phase == PH_DATA && !r.rw && !start && !stop
    |=> sda_oe [*1] ##0 r.state == LS_ACK)
    else $error("data byte not acknowledged");

  a_stop_releases: assert property (@(posedge link_clk) disable iff (!lnk_nrst)
    ce_l && stop && !start |=> r.state == LS_IDLE && !sda_oe)
    else $error("stop did not release the bus");

  a_count_first: assert property (@(posedge link_clk) disable iff (!lnk_nrst)
    ce_l && r.state == LS_ACK && r.phase == PH_ADDR && r.rw && !r.is_byte && !r.head_sent
    && fall && !start && !stop |=> r.state == LS_TX && r.sr == BLOCK_COUNT)
    else $error("block read did not begin with the count");

  a_tx_msb_first: assert property (@(posedge link_clk) disable iff (!lnk_nrst)
    r.state == LS_TX |-> sda_oe == !r.sr[7])
    else $error("transmit bit is not the byte msb");

  a_host_nack_ends: assert property (@(posedge link_clk) disable iff (!lnk_nrst)
    ce_l && r.state == LS_MACK && fall && r.nack && !start && !stop
    |=> r.state == LS_IDLE && !sda_oe)
    else $error("read continued after host nack");

  a_power_defaults: assert property (@(posedge core_clk)
    !nrst |=> cfg_bytes == CFG_DEFAULTS)
    else $error("configuration defaults not loaded");

  a_write_applies: assert property (@(posedge core_clk) disable iff (!nrst)
    ce && rd_if.valid && pop_idx < IDX_W'(CFG_BYTES)
    |=> c_r.cfg[$past(pop_idx)] == $past(rd_if.data[DATA_W-1:0]))
    else $error("written byte not applied to outputs");

  // main scenarios
  c_byte_write: cover property (@(posedge link_clk) r.push && r.is_byte && wr_if.ready);
  c_block_write: cover property (@(posedge link_clk) r.push && !r.is_byte && wr_if.ready);
  c_byte_read: cover property (@(posedge link_clk)
    r.state == LS_MACK && r.is_byte && fall && r.nack);
  c_block_read: cover property (@(posedge link_clk)
    r.state == LS_MACK && !r.is_byte && r.head_sent && fall && !r.nack);
endmodule : smbus_config_slave

// ==== smbus_host_model.sv ====
// bus host model: drives scl and sda low or lets them float high
// assumes: the bench resolves both wires with pull-ups from every enable
module smbus_host_model (
  input wire logic link_clk,
  input wire logic scl,
  input wire logic sda,
  output logic scl_low,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int Q = 8;
  int stuck = 0;

  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge link_clk);
  endtask : tick

  // release scl, honour a stretch by the slave, but never wait forever
  task automatic rise();
    int w;
    w = 0;
    scl_low <= 1'b0;
    tick(1);
    while (!scl && w < 4000) begin
      tick(1);
      w++;
    end
    if (w == 4000) stuck++;
    tick(Q / 2);
  endtask : rise

  // sda only moves while scl is low, sampled mid high phase
  task automatic bit_io(input logic b, output logic r);
    sda_low <= ~b;
    tick(Q);
    rise();
    r = sda;
    tick(Q / 2);
    scl_low <= 1'b1;
    tick(2);
  endtask : bit_io

  // start, or repeated start when scl is held low
  task automatic start();
    sda_low <= 1'b0;
    tick(Q);
    if (scl_low) rise();
    sda_low <= 1'b1;
    tick(Q);
    scl_low <= 1'b1;
    tick(2);
  endtask : start

  task automatic stop();
    sda_low <= 1'b1;
    tick(Q);
    rise();
    sda_low <= 1'b0;
    tick(Q);
  endtask : stop

  // eight bits msb first, then the slave's acknowledge
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, ack);
  endtask : send

  // host acks all but the last byte, which it answers with nack
  task automatic recv(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(nack, r);
  endtask : recv
endmodule : smbus_host_model

// ==== smbus_config_slave_test.sv ====
// self-checking bench of the configuration slave with a host model
// assumes: open-drain wires pulled up here, link clock unrelated to core clock
module smbus_config_slave_test;
  import smbus_cfg_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] idx; logic [7:0] data;} row_t;
  localparam row_t ROWS [4] = '{'{8'h00, 8'hA5}, '{8'h01, 8'h00}, '{8'h02, 8'hFF},
    '{8'h0F, 8'h3C}};
  logic core_clk = 1'b0;
  logic link_clk = 1'b0;
  logic nrst;
  logic ce;
  logic scl_low, sda_low, scl_out, scl_oe, sda_out, sda_oe;
  logic a, nak;
  logic [7:0] d;
  logic [CFG_BYTES*8-1:0] cfg_bytes, exp_cfg;
  wire scl, sda;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;

  // pull-ups: a released wire reads high
  assign scl = ~(scl_low | scl_oe);
  assign sda = ~(sda_low | sda_oe);
  always #12.5 core_clk = ~core_clk;
  // link clock starts off the core grid so the two edges never line up
  always begin
    #3.3;
    forever #7.5 link_clk = ~link_clk;
  end

  smbus_config_slave dut (.core_clk(core_clk), .nrst(nrst), .ce(ce), .link_clk(link_clk),
    .scl_in(scl), .sda_in(sda), .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out),
    .sda_oe(sda_oe), .cfg_bytes(cfg_bytes));
  smbus_host_model host (.link_clk(link_clk), .scl(scl), .sda(sda), .scl_low(scl_low),
    .sda_low(sda_low));

  task automatic check(input logic [127:0] seen, input logic [127:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t %s: seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  // a hung bus or a stuck wait ends the run here
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      finish_test();
    end
  end

  task automatic tx(input logic [7:0] v);
    host.send(v, a);
    nak = nak | a;
  endtask : tx

  // applied bytes cross the fifo, so allow a bounded settling time
  task automatic settle(input string what);
    int n;
    n = 0;
    while (cfg_bytes !== exp_cfg && n < 60) begin
      @(posedge core_clk);
      n++;
    end
    check(cfg_bytes, exp_cfg, what);
  endtask : settle

  task automatic byte_wr(input logic [7:0] idx, input logic [7:0] v);
    nak = 1'b0;
    host.start();
    tx({SLAVE_ADDR, 1'b0});
    tx({1'b1, idx[6:0]});
    tx(v);
    host.stop();
    if (idx < CFG_BYTES) exp_cfg[8 * idx +: 8] = v;
    check(nak, 1'b0, "byte write acks");
  endtask : byte_wr

  task automatic byte_rd(input logic [7:0] idx, output logic [7:0] v);
    nak = 1'b0;
    host.start();
    tx({SLAVE_ADDR, 1'b0});
    tx({1'b1, idx[6:0]});
    host.start();
    tx({SLAVE_ADDR, 1'b1});
    host.recv(1'b1, v);
    host.stop();
    check(nak, 1'b0, "byte read acks");
  endtask : byte_rd

  // block write of n bytes from byte 0, stop after the last one
  task automatic blk_wr(input int n, input logic [7:0] base);
    nak = 1'b0;
    host.start();
    tx({SLAVE_ADDR, 1'b0});
    tx(8'h00);
    tx(8'(n));
    for (int k = 0; k < n; k++) begin
      tx(base + 8'(k));
      if (k < CFG_BYTES) exp_cfg[8 * k +: 8] = base + 8'(k);
    end
    host.stop();
    check(nak, 1'b0, "block write acks");
  endtask : blk_wr

  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    exp_cfg = CFG_DEFAULTS;
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge core_clk);
    check(cfg_bytes, CFG_DEFAULTS, "power-up bytes");
    check({scl_out, scl_oe, sda_out, sda_oe}, 4'h0, "pins released after reset");
    $display("reset test done");

    // ordinary rows: write a byte, see it applied, read it back
    foreach (ROWS[i]) begin
      byte_wr(ROWS[i].idx, ROWS[i].data);
      settle("byte write applied");
      byte_rd(ROWS[i].idx, d);
      check(d, ROWS[i].data, "byte read data");
    end
    $display("row tests done");

    // another device's address must get no acknowledge
    host.start();
    host.send(8'hA4, a);
    host.stop();
    check(a, 1'b1, "foreign address ack");
    byte_wr(8'h10, 8'h77);
    settle("index past the last byte dropped");
    $display("refusal tests done");

    // block write stopped after three bytes keeps those three
    blk_wr(3, 8'h11);
    settle("short block write");
    // block write running past the last byte, once the previous one has settled
    blk_wr(18, 8'h40);
    settle("long block write");
    $display("block write tests done");

    // block read: count, then bytes 0 to 4, host nacks the last
    nak = 1'b0;
    host.start();
    tx({SLAVE_ADDR, 1'b0});
    tx(8'h00);
    host.start();
    tx({SLAVE_ADDR, 1'b1});
    host.recv(1'b0, d);
    check(d, BLOCK_COUNT, "block read count");
    for (int k = 0; k < 5; k++) begin
      host.recv(k == 4, d);
      check(d, exp_cfg[8 * k +: 8], "block read data");
    end
    host.stop();
    check(nak, 1'b0, "block read acks");
    check(host.stuck, 0, "scl never held low for good");
    $display("block read test done");
    byte_rd(8'h02, d);
    check(d, 8'h42, "byte read after block read");
    $display("final read test done");

    // reset in mid-run brings back the defaults, also in the read-back copy
    @(posedge core_clk);
    nrst <= 1'b0;
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge core_clk);
    exp_cfg = CFG_DEFAULTS;
    check(cfg_bytes, CFG_DEFAULTS, "defaults after mid-run reset");
    byte_rd(8'h01, d);
    check(d, CFG_DEFAULTS[15:8], "default byte read back");
    $display("mid-run reset test done");
    finish_test();
  end
endmodule : smbus_config_slave_test
